/* File: gac_pkg.sv */
// Shared constants for the conversion sequencer and its host controller
package gac_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int ADC_WAKE_NS = 2000;
  localparam int ADC_WAKE_CYC = (ADC_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ADC_WAKE_LOAD = 8'(ADC_WAKE_CYC - 1);
  localparam int IVL_UNIT_NS = 1000;
  localparam int IVL_UNIT_CYC = IVL_UNIT_NS / CLK_PERIOD_NS;

  // Device register offsets on the link
  localparam logic [7:0] OFS_OS_SEL = 8'h00;
  localparam logic [7:0] OFS_OS_RES_LO = 8'h01;
  localparam logic [7:0] OFS_OS_RES_HI = 8'h02;
  localparam logic [7:0] OFS_PER_SEL = 8'h03;
  localparam logic [7:0] OFS_PER_CTRL = 8'h04;
  localparam logic [7:0] OFS_S0_TH_LO = 8'h05;
  localparam logic [7:0] OFS_S0_TH_HI = 8'h06;
  localparam logic [7:0] OFS_S1_TH_LO = 8'h07;
  localparam logic [7:0] OFS_S1_TH_HI = 8'h08;
  localparam logic [7:0] OFS_S0_RES_LO = 8'h09;
  localparam logic [7:0] OFS_S0_RES_HI = 8'h0a;
  localparam logic [7:0] OFS_S1_RES_LO = 8'h0b;
  localparam logic [7:0] OFS_S1_RES_HI = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h0d;

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [11:0] RES_RST = 12'h000;

  // Field positions
  localparam int OS_START_BIT = 4;
  localparam int SEL1_LSB = 4;
  localparam int CTRL_EN0 = 0;
  localparam int CTRL_EN1 = 1;
  localparam int CTRL_SD0 = 2;
  localparam int CTRL_SD1 = 3;
  localparam int CTRL_IVL_LSB = 4;
  localparam int TH_POL_BIT = 7;
  localparam int ST_OS_DONE = 0;
  localparam int ST_CROSS0 = 1;
  localparam int ST_CROSS1 = 2;
  localparam int ST_OS_REFUSED = 3;

  // Channel limits in low-power states
  localparam logic [2:0] LP_MAX_CH = 3'h4;
  localparam logic [2:0] THERM_CH_A = 3'h5;
  localparam logic [2:0] THERM_CH_B = 3'h6;

  // Host Avalon map
  localparam logic [4:0] AV_DEV_ADDR = 5'h00;
  localparam logic [4:0] AV_DEV_DATA = 5'h04;
  localparam logic [4:0] AV_STATUS = 5'h08;
  localparam logic [4:0] AV_CAL = 5'h0c;
  localparam logic [4:0] AV_TRIM_AB = 5'h10;
  localparam logic [4:0] AV_TRIM_C = 5'h14;
  localparam int CAL_HS_BIT = 15;
  localparam int CAL_CH_LSB = 12;

  // Calibration reference codes
  localparam int CAL_X1 = 2064;
  localparam int CAL_X2 = 3112;
  localparam int CAL_DX = CAL_X2 - CAL_X1;
  localparam logic [2:0] CAL_CH_VCC = 3'h3;
  localparam logic [4:0] CAL_STEPS = 5'h18;
endpackage

/* File: gac_link_if.sv */
// Register link and event lines between host controller and sequencer
`timescale 1ns/1ps
interface gac_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic oneshotDoneIrq;
  logic periodicIrq;
  logic shutdownReq;
  modport device(input req, input we, input addr, input wdata, output rdata, output ack,
    output oneshotDoneIrq, output periodicIrq, output shutdownReq);
  modport host(output req, output we, output addr, output wdata, input rdata, input ack,
    input oneshotDoneIrq, input periodicIrq, input shutdownReq);
endinterface

/* File: gac_slot.sv */
// One periodic slot: latest result and threshold compare
`timescale 1ns/1ps
module gac_slot (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic store,
  input wire logic [11:0] result,
  input wire logic [11:0] threshold,
  input wire logic above,
  output logic [11:0] latest_ff,
  output logic cross_ff
);
  // Newest result always replaces the old one, read or not
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latest_ff <= gac_pkg::RES_RST;
    end else if (store) begin
      latest_ff <= result; // RULE8 RULE12
    end
  end

  // Full-width compare in the programmed direction, one-cycle event
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cross_ff <= 1'b0;
    end else begin
      cross_ff <= store && (above ? (result > threshold) : (result < threshold)); // RULE11 RULE21
    end
  end
endmodule

/* File: gac_device_end.sv */
// Conversion sequencer: register file, one-shot and periodic scheduling
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
// How it works
// (RULE1) Host picks channel, then writes trigger
// (RULE2) One-shot done raises interrupt, stores result
// (RULE3) Host discards first one-shot after reset
// (RULE4) Periodic mode compares one or two channels
// (RULE5) Each slot has own threshold, polarity
// (RULE6) Host programs interval and per-slot enables
// (RULE7) Converter powered automatically around conversions
// (RULE8) Each slot holds its latest result
// (RULE9) Queue ascending; lower result into slot zero (the code puts the lower channel's result into slot zero)
// (RULE10) Host puts lower channel in slot zero
// (RULE11) Threshold crossing raises interrupt, keeps result
// (RULE12) Newer conversion overwrites unread results
// (RULE13) Pending interrupts never stop periodic conversions
// (RULE14) Crossing requests shutdown when slot enabled
// (RULE15) Sleep or off: only channels 0-4
// (RULE16) Sleep: channels 5,6 if thermal on
// (RULE17) Host corrects code with two-point gain/offset
// (RULE18) Trim pair chosen by channel and sense
// (RULE19) One-shot request beats periodic request
// (RULE20) 12-bit results, eight inputs, host readable
// (RULE21) Full-width compare; flag held until cleared
module gac_device_end (
  input wire logic clk,
  input wire logic sys_rst,
  gac_link_if.device link,
  output logic adcPower_ff,
  output logic adcStart_ff,
  output logic [2:0] adcChan_ff,
  input wire logic adcDone,
  input wire logic [11:0] adcResult,
  input wire logic sleepPin,
  input wire logic offPin,
  input wire logic thermOffPin
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_PICK, ST_WAIT} gac_seq_state_type;

  gac_seq_state_type state_ff;
  logic [2:0] syncA_ff;
  logic [2:0] syncB_ff;
  logic [2:0] syncC_ff;
  logic [2:0] mode_ff;
  logic [2:0] osChan_ff;
  logic swPend_ff;
  logic [7:0] perSel_ff;
  logic [7:0] perCtrl_ff;
  logic [7:0] th0Lo_ff;
  logic [7:0] th0Hi_ff;
  logic [7:0] th1Lo_ff;
  logic [7:0] th1Hi_ff;
  logic [11:0] osResult_ff;
  logic [3:0] status_ff;
  logic [7:0] rdata_ff;
  logic ack_ff;
  logic osIrq_ff;
  logic perIrq_ff;
  logic shutdown_ff;
  logic [11:0] timer_ff;
  logic [1:0] autoQ_ff;
  logic [2:0] q0Ch_ff;
  logic [2:0] q1Ch_ff;
  logic q0Slot_ff;
  logic q1Slot_ff;
  logic [7:0] wake_ff;
  logic jobSw_ff;
  logic jobSlot_ff;
  logic [11:0] slot0Res;
  logic [11:0] slot1Res;
  logic cross0;
  logic cross1;
  logic access;
  logic wrStrobe;
  logic [7:0] rdMux;
  logic [11:0] periodCyc;
  logic fire;
  logic inPick;
  logic swTake;
  logic q0Take;
  logic q1Take;
  logic pickAny;
  logic [2:0] pickCh;
  logic pickSlot;
  logic pickOk;
  logic osRefused;
  logic store0;
  logic store1;
  logic osDone;
  logic [2:0] ch0;
  logic [2:0] ch1;

  // Low-power restriction on which inputs may be converted
  function automatic logic chanOk(input logic [2:0] ch, input logic [2:0] mode);
    logic inSleep;
    logic inOff;
    logic thermOff;
    inSleep = mode[2];
    inOff = mode[1];
    thermOff = mode[0];
    chanOk = !(inSleep || inOff) || (ch <= gac_pkg::LP_MAX_CH) || // RULE15
      (inSleep && !inOff && !thermOff &&
      (ch == gac_pkg::THERM_CH_A || ch == gac_pkg::THERM_CH_B)); // RULE16
  endfunction

  // State pins are asynchronous; a level counts once two stages agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_ff <= 3'h0;
      syncB_ff <= 3'h0;
      syncC_ff <= 3'h0;
      mode_ff <= 3'h0;
    end else begin
      syncA_ff <= {sleepPin, offPin, thermOffPin};
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
      mode_ff <= (syncB_ff & syncC_ff) | (mode_ff & (syncB_ff | syncC_ff));
    end
  end

  // Link access: one answer per request, ack drops the next cycle
  assign access = link.req && !ack_ff;
  assign wrStrobe = access && link.we;

  // Readback of all registers; unmapped offsets read zero
  always_comb begin
    case (link.addr)
      gac_pkg::OFS_OS_SEL: rdMux = {3'h0, swPend_ff, 1'b0, osChan_ff};
      gac_pkg::OFS_OS_RES_LO: rdMux = osResult_ff[7:0]; // RULE20
      gac_pkg::OFS_OS_RES_HI: rdMux = {4'h0, osResult_ff[11:8]};
      gac_pkg::OFS_PER_SEL: rdMux = perSel_ff;
      gac_pkg::OFS_PER_CTRL: rdMux = perCtrl_ff;
      gac_pkg::OFS_S0_TH_LO: rdMux = th0Lo_ff;
      gac_pkg::OFS_S0_TH_HI: rdMux = th0Hi_ff;
      gac_pkg::OFS_S1_TH_LO: rdMux = th1Lo_ff;
      gac_pkg::OFS_S1_TH_HI: rdMux = th1Hi_ff;
      gac_pkg::OFS_S0_RES_LO: rdMux = slot0Res[7:0];
      gac_pkg::OFS_S0_RES_HI: rdMux = {4'h0, slot0Res[11:8]};
      gac_pkg::OFS_S1_RES_LO: rdMux = slot1Res[7:0];
      gac_pkg::OFS_S1_RES_HI: rdMux = {4'h0, slot1Res[11:8]};
      gac_pkg::OFS_STATUS: rdMux = {4'h0, status_ff};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= gac_pkg::REG_RST;
    end else begin
      ack_ff <= access;
      if (access && !link.we) begin
        rdata_ff <= rdMux;
      end
    end
  end

  // Writable configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      perSel_ff <= gac_pkg::REG_RST;
      perCtrl_ff <= gac_pkg::REG_RST;
      th0Lo_ff <= gac_pkg::REG_RST;
      th0Hi_ff <= gac_pkg::REG_RST;
      th1Lo_ff <= gac_pkg::REG_RST;
      th1Hi_ff <= gac_pkg::REG_RST;
    end else if (wrStrobe) begin
      case (link.addr)
        gac_pkg::OFS_PER_SEL: perSel_ff <= link.wdata; // RULE4 RULE10
        gac_pkg::OFS_PER_CTRL: perCtrl_ff <= link.wdata; // RULE6
        gac_pkg::OFS_S0_TH_LO: th0Lo_ff <= link.wdata; // RULE5
        gac_pkg::OFS_S0_TH_HI: th0Hi_ff <= link.wdata;
        gac_pkg::OFS_S1_TH_LO: th1Lo_ff <= link.wdata;
        gac_pkg::OFS_S1_TH_HI: th1Hi_ff <= link.wdata;
        default: ;
      endcase
    end
  end

  // One-shot request: channel and trigger share one write; a new trigger wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osChan_ff <= 3'h0;
      swPend_ff <= 1'b0;
    end else if (wrStrobe && link.addr == gac_pkg::OFS_OS_SEL) begin
      osChan_ff <= link.wdata[2:0];
      swPend_ff <= link.wdata[gac_pkg::OS_START_BIT] || (swPend_ff && !swTake); // RULE1
    end else if (swTake) begin
      swPend_ff <= 1'b0;
    end
  end

  // Interval timer; runs while any slot is enabled
  assign periodCyc = 12'(({1'b0, perCtrl_ff[7:gac_pkg::CTRL_IVL_LSB]} + 5'h01) *
    gac_pkg::IVL_UNIT_CYC);
  assign fire = (perCtrl_ff[gac_pkg::CTRL_EN0] || perCtrl_ff[gac_pkg::CTRL_EN1]) &&
    (timer_ff == periodCyc - 12'h001);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_ff <= 12'h000;
    end else if (fire || !(perCtrl_ff[gac_pkg::CTRL_EN0] || perCtrl_ff[gac_pkg::CTRL_EN1])) begin
      timer_ff <= 12'h000;
    end else begin
      timer_ff <= timer_ff + 12'h001;
    end
  end

  // Scheduler picks: one-shot first, then the periodic queue in order
  assign inPick = (state_ff == ST_PICK);
  assign swTake = inPick && swPend_ff; // RULE19
  assign q0Take = inPick && !swPend_ff && autoQ_ff[0];
  assign q1Take = inPick && !swPend_ff && !autoQ_ff[0] && autoQ_ff[1];
  assign pickAny = swPend_ff || (autoQ_ff != 2'b00);
  assign pickCh = swPend_ff ? osChan_ff : (autoQ_ff[0] ? q0Ch_ff : q1Ch_ff);
  assign pickSlot = autoQ_ff[0] ? q0Slot_ff : q1Slot_ff;
  assign pickOk = inPick && pickAny && chanOk(pickCh, mode_ff);
  assign osRefused = swTake && !chanOk(osChan_ff, mode_ff);
  localparam int SEL1_TOP = gac_pkg::SEL1_LSB + 2;
  assign ch0 = perSel_ff[2:0];
  assign ch1 = perSel_ff[SEL1_TOP:gac_pkg::SEL1_LSB];

  // Queue reload on each interval; a late reload just refreshes the work
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      autoQ_ff <= 2'b00;
      q0Ch_ff <= 3'h0;
      q1Ch_ff <= 3'h0;
      q0Slot_ff <= 1'b0;
      q1Slot_ff <= 1'b1;
    end else if (fire) begin
      if (perCtrl_ff[gac_pkg::CTRL_EN0] && perCtrl_ff[gac_pkg::CTRL_EN1]) begin
        autoQ_ff <= 2'b11;
        q0Ch_ff <= (ch0 <= ch1) ? ch0 : ch1; // RULE9
        q1Ch_ff <= (ch0 <= ch1) ? ch1 : ch0;
        q0Slot_ff <= 1'b0;
        q1Slot_ff <= 1'b1;
      end else begin
        autoQ_ff <= 2'b01;
        q0Ch_ff <= perCtrl_ff[gac_pkg::CTRL_EN0] ? ch0 : ch1;
        q0Slot_ff <= !perCtrl_ff[gac_pkg::CTRL_EN0];
      end
    end else begin
      if (q0Take) begin
        autoQ_ff[0] <= 1'b0; // RULE13
      end
      if (q1Take) begin
        autoQ_ff[1] <= 1'b0;
      end
    end
  end

  // Sequencer; the converter is powered only while work is queued or a conversion is in flight
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      wake_ff <= 8'h00;
      adcPower_ff <= 1'b0;
      adcStart_ff <= 1'b0;
      adcChan_ff <= 3'h0;
      jobSw_ff <= 1'b0;
      jobSlot_ff <= 1'b0;
    end else begin
      adcStart_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (pickAny) begin
            adcPower_ff <= 1'b1; // RULE7
            wake_ff <= gac_pkg::ADC_WAKE_LOAD;
            state_ff <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (wake_ff == 8'h00) begin
            state_ff <= ST_PICK;
          end else begin
            wake_ff <= wake_ff - 8'h01;
          end
        end
        ST_PICK: begin
          if (pickOk) begin
            adcChan_ff <= pickCh;
            jobSw_ff <= swPend_ff;
            jobSlot_ff <= pickSlot;
            adcStart_ff <= 1'b1;
            state_ff <= ST_WAIT;
          end else if (!pickAny) begin
            adcPower_ff <= 1'b0; // RULE7
            state_ff <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (adcDone) begin
            state_ff <= ST_PICK;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Result steering
  assign osDone = (state_ff == ST_WAIT) && adcDone && jobSw_ff;
  assign store0 = (state_ff == ST_WAIT) && adcDone && !jobSw_ff && !jobSlot_ff;
  assign store1 = (state_ff == ST_WAIT) && adcDone && !jobSw_ff && jobSlot_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osResult_ff <= gac_pkg::RES_RST;
    end else if (osDone) begin
      osResult_ff <= adcResult; // RULE2
    end
  end

  gac_slot slot0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .store(store0),
    .result(adcResult),
    .threshold({th0Hi_ff[3:0], th0Lo_ff}),
    .above(th0Hi_ff[gac_pkg::TH_POL_BIT]),
    .latest_ff(slot0Res),
    .cross_ff(cross0)
  );

  gac_slot slot1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .store(store1),
    .result(adcResult),
    .threshold({th1Hi_ff[3:0], th1Lo_ff}),
    .above(th1Hi_ff[gac_pkg::TH_POL_BIT]),
    .latest_ff(slot1Res),
    .cross_ff(cross1)
  );

  // Sticky flags, write one to clear; a same-cycle event wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_ff <= 4'h0;
    end else begin
      status_ff <= {osRefused, cross1, cross0, osDone} | // RULE2 RULE11
        (status_ff & ~((wrStrobe && link.addr == gac_pkg::OFS_STATUS) ?
        link.wdata[3:0] : 4'h0)); // RULE21
    end
  end

  // Event lines toward the host
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osIrq_ff <= 1'b0;
      perIrq_ff <= 1'b0;
      shutdown_ff <= 1'b0;
    end else begin
      osIrq_ff <= status_ff[gac_pkg::ST_OS_DONE];
      perIrq_ff <= status_ff[gac_pkg::ST_CROSS0] || status_ff[gac_pkg::ST_CROSS1];
      shutdown_ff <= (cross0 && perCtrl_ff[gac_pkg::CTRL_SD0]) ||
        (cross1 && perCtrl_ff[gac_pkg::CTRL_SD1]); // RULE14
    end
  end

  assign link.rdata = rdata_ff;
  assign link.ack = ack_ff;
  assign link.oneshotDoneIrq = osIrq_ff;
  assign link.periodicIrq = perIrq_ff;
  assign link.shutdownReq = shutdown_ff;
endmodule

/* File: gac_host_end.sv */
// Host controller: Avalon-MM slave that drives the link and corrects codes
`timescale 1ns/1ps
module gac_host_end (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  gac_link_if.host link
);
  logic [7:0] devAddr_ff;
  logic req_ff;
  logic we_ff;
  logic [7:0] wdata_ff;
  logic busy_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic sdSeen_ff;
  logic osIrqDly_ff;
  logic fresh_ff;
  logic discard_ff;
  logic [31:0] trimAb_ff;
  logic [15:0] trimC_ff;
  logic [4:0] calCnt_ff;
  logic [23:0] calNum_ff;
  logic [12:0] calDen_ff;
  logic [12:0] calRem_ff;
  logic [12:0] trial;
  logic commit;
  logic osRise;
  logic [4:0] hostStatus;
  logic [11:0] calOut;
  logic [2:0] calCh;
  logic signed [7:0] d1;
  logic signed [7:0] d2;
  logic signed [8:0] dD;
  logic signed [31:0] numS;
  logic signed [31:0] denS;

  // Local writes land at the edge where waitrequest is seen low
  assign commit = avs_write && !wait_ff;
  assign osRise = link.oneshotDoneIrq && !osIrqDly_ff;
  assign hostStatus = {busy_ff, discard_ff, sdSeen_ff, link.periodicIrq, link.oneshotDoneIrq};
  assign calOut = (calNum_ff[23:12] != 12'h000) ? 12'hfff : calNum_ff[11:0];

  // Bus front end; link accesses hold waitrequest until the device acks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff <= 1'b1;
      busy_ff <= 1'b0;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      wdata_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= 1'b1;
      if (busy_ff) begin
        if (link.ack) begin
          busy_ff <= 1'b0;
          req_ff <= 1'b0;
          rdata_ff <= {24'h00_0000, link.rdata};
          wait_ff <= 1'b0;
        end
      end else if (wait_ff && (avs_read || avs_write)) begin
        wait_ff <= (avs_address == gac_pkg::AV_DEV_DATA);
        case (avs_address)
          gac_pkg::AV_DEV_DATA: begin
            busy_ff <= 1'b1; // RULE1
            req_ff <= 1'b1;
            we_ff <= avs_write;
            wdata_ff <= avs_writedata[7:0];
          end
          gac_pkg::AV_DEV_ADDR: rdata_ff <= {24'h00_0000, devAddr_ff};
          gac_pkg::AV_STATUS: rdata_ff <= {27'h000_0000, hostStatus};
          gac_pkg::AV_CAL: rdata_ff <= {19'h0_0000, (calCnt_ff != 5'h00), calOut};
          gac_pkg::AV_TRIM_AB: rdata_ff <= trimAb_ff;
          gac_pkg::AV_TRIM_C: rdata_ff <= {16'h0000, trimC_ff};
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-owned settings
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      devAddr_ff <= gac_pkg::REG_RST;
      trimAb_ff <= 32'h0000_0000;
      trimC_ff <= 16'h0000;
    end else if (commit) begin
      case (avs_address)
        gac_pkg::AV_DEV_ADDR: devAddr_ff <= avs_writedata[7:0]; // RULE6
        gac_pkg::AV_TRIM_AB: trimAb_ff <= avs_writedata;
        gac_pkg::AV_TRIM_C: trimC_ff <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end

  // Shutdown seen is sticky; a new request beats the clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdSeen_ff <= 1'b0;
    end else begin
      sdSeen_ff <= link.shutdownReq ||
        (sdSeen_ff && !(commit && avs_address == gac_pkg::AV_STATUS && avs_writedata[2]));
    end
  end

  // First one-shot after reset is flagged so software throws it away
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osIrqDly_ff <= 1'b0;
      fresh_ff <= 1'b1;
      discard_ff <= 1'b0;
    end else begin
      osIrqDly_ff <= link.oneshotDoneIrq;
      if (osRise) begin
        discard_ff <= fresh_ff; // RULE3
        fresh_ff <= 1'b0;
      end
    end
  end

  // Trim pair: one shared pair for every channel except the supply sense, which has two pairs
  assign calCh = avs_writedata[14:12];
  always_comb begin
    if (calCh == gac_pkg::CAL_CH_VCC) begin
      d1 = avs_writedata[gac_pkg::CAL_HS_BIT] ? trimC_ff[7:0] : trimAb_ff[23:16]; // RULE18
      d2 = avs_writedata[gac_pkg::CAL_HS_BIT] ? trimC_ff[15:8] : trimAb_ff[31:24];
    end else begin
      d1 = trimAb_ff[7:0];
      d2 = trimAb_ff[15:8];
    end
  end

  // a' = ((a - D1) * dX + dD * X1) / (dX + dD), which is (a - b) / k
  assign dD = 9'(d2) - 9'(d1);
  assign numS = ($signed({20'h0_0000, avs_writedata[11:0]}) - 32'(d1)) * gac_pkg::CAL_DX +
    32'(dD) * gac_pkg::CAL_X1; // RULE17
  assign denS = gac_pkg::CAL_DX + 32'(dD);
  assign trial = {calRem_ff[11:0], calNum_ff[23]};

  // Serial divider, one quotient bit per cycle; negative codes clamp to zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      calCnt_ff <= 5'h00;
      calNum_ff <= 24'h00_0000;
      calDen_ff <= 13'h0001;
      calRem_ff <= 13'h0000;
    end else if (commit && avs_address == gac_pkg::AV_CAL) begin
      calCnt_ff <= gac_pkg::CAL_STEPS;
      calNum_ff <= (numS < 0) ? 24'h00_0000 : numS[23:0];
      calDen_ff <= denS[12:0];
      calRem_ff <= 13'h0000;
    end else if (calCnt_ff != 5'h00) begin
      calCnt_ff <= calCnt_ff - 5'h01;
      calNum_ff <= {calNum_ff[22:0], trial >= calDen_ff};
      calRem_ff <= (trial >= calDen_ff) ? trial - calDen_ff : trial;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign link.req = req_ff;
  assign link.we = we_ff;
  assign link.addr = devAddr_ff;
  assign link.wdata = wdata_ff;
endmodule

/* File: gac_link_chk.sv */
// Checks on the link between host end and sequencer
`timescale 1ns/1ps
module gac_link_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic oneshotDoneIrq,
  input wire logic periodicIrq,
  input wire logic shutdownReq
);
  // Status clear seen by the device; the flag may follow one or two edges later
  wire clrSeen = ack && we && addr == gac_pkg::OFS_STATUS;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Handshake timing on both sides
  AST_ACK_NEXT: assert property (req && !ack |=> ack) else $error("ack late");
  AST_ACK_PULSE: assert property (ack |=> !ack) else $error("ack too wide");
  AST_ACK_CAUSE: assert property (ack |-> $past(req && !ack)) else $error("ack no req");
  AST_REQ_DROP: assert property (ack |=> !req) else $error("req held");
  // Shutdown request is a pulse that comes with the slot flag
  AST_SD_PULSE: assert property (shutdownReq |=> !shutdownReq) else $error("sd wide");
  AST_SD_IRQ: assert property (shutdownReq |-> ##[0:3] periodicIrq)
    else $error("sd no irq");
  // Flags fall only after a host clear
  AST_IRQ_HOLD: assert property ($fell(periodicIrq) |-> $past(clrSeen) || $past(clrSeen, 2))
    else $error("irq dropped");
  AST_DONE_HOLD: assert property ($fell(oneshotDoneIrq) |-> $past(clrSeen) || $past(clrSeen, 2))
    else $error("done dropped");
endmodule

/* File: tb_top.sv */
// Self-checking bench joining host end and sequencer
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0, sys_rst = 1'h1, avRd = 1'h0, avWr = 1'h0, adcDone = 1'h0, slp = 1'h0;
  logic [4:0] avAddr = 5'h00;
  logic [31:0] avWdata = 32'h0, avRdata;
  logic avWait, adcPower, adcStart;
  logic [2:0] adcChan, ch, pick;
  logic [11:0] adcResult = 12'h000, res;
  logic [11:0] lastRes [8];
  logic [3:0] cnt = 4'h0;
  logic [63:0] e;
  logic [63:0] expQ [$];
  int numErrors = 0, checked = 0;
  gac_link_if lk ();
  gac_host_end gac_host_end_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avAddr),
    .avs_read(avRd), .avs_write(avWr), .avs_writedata(avWdata), .avs_readdata(avRdata),
    .avs_waitrequest(avWait), .link(lk.host));
  gac_device_end gac_device_end_i (.clk(clk), .sys_rst(sys_rst), .link(lk.device),
    .adcPower_ff(adcPower), .adcStart_ff(adcStart), .adcChan_ff(adcChan), .adcDone(adcDone),
    .adcResult(adcResult), .sleepPin(slp), .offPin(1'h0), .thermOffPin(1'h0));
  gac_link_chk gac_link_chk_i (.clk(clk), .sys_rst(sys_rst), .req(lk.req), .we(lk.we),
    .addr(lk.addr), .wdata(lk.wdata), .rdata(lk.rdata), .ack(lk.ack),
    .oneshotDoneIrq(lk.oneshotDoneIrq), .periodicIrq(lk.periodicIrq),
    .shutdownReq(lk.shutdownReq));
  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  // Converter stand-in; channel in top bits shows which result landed where
  always @(posedge clk) begin
    adcDone <= 1'h0;
    adcResult <= ~adcResult; // Stale bus data never looks valid
    if (cnt == 4'h1) begin
      adcDone <= 1'h1;
      adcResult <= res;
      lastRes[ch] <= res;
    end
    if (cnt != 4'h0) cnt <= cnt - 4'h1;
    if (adcStart) begin
      cnt <= 4'h5;
      ch <= adcChan;
      res <= {adcChan, 9'($urandom)};
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Oldest noted result is compared when a read completes
  always @(posedge clk) begin
    if (avRd && avWait === 1'h0 && expQ.size() != 0) begin
      e = expQ.pop_front();
      chk(avRdata & e[63:32], e[31:0]);
    end
  end
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avRd <= !w;
    avWr <= w;
    avAddr <= a;
    avWdata <= d;
    do @(posedge clk); while (avWait !== 1'h0);
    avRd <= 1'h0;
    avWr <= 1'h0;
  endtask
  task automatic rdx(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v);
    expQ.push_back({m, v});
    av(1'h0, a, 32'h0);
  endtask
  task automatic dev(input logic w, logic [7:0] o, logic [31:0] m, v);
    av(1'h1, gac_pkg::AV_DEV_ADDR, {24'h0, o});
    if (w) av(1'h1, gac_pkg::AV_DEV_DATA, v);
    else rdx(gac_pkg::AV_DEV_DATA, m, v);
  endtask
  task automatic waitIrq(input bit p);
    for (int i = 0; i < 2000 && (p ? lk.periodicIrq : lk.oneshotDoneIrq) !== 1'h1; i++)
      @(posedge clk);
    chk({31'h0, p ? lk.periodicIrq : lk.oneshotDoneIrq}, 32'h1);
  endtask
  task automatic conclude();
    if (numErrors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    conclude();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h0d00));
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    // Two one-shots: only the first after reset is marked for discard
    for (int i = 0; i < 2; i++) begin
      pick = 3'($urandom_range(7, 0));
      dev(1'h1, gac_pkg::OFS_OS_SEL, 0, {29'h0, pick});
      dev(1'h1, gac_pkg::OFS_OS_SEL, 0, {29'h2, pick});
      waitIrq(1'b0);
      dev(1'h0, gac_pkg::OFS_OS_RES_LO, 32'hff, {24'h0, lastRes[pick][7:0]});
      dev(1'h0, gac_pkg::OFS_OS_RES_HI, 32'h0f, {28'h0, lastRes[pick][11:8]});
      rdx(gac_pkg::AV_STATUS, 32'h09, {28'h0, i == 0, 3'h1});
      dev(1'h1, gac_pkg::OFS_STATUS, 0, 32'h01);
    end
    // Slot fields reversed on purpose; slot zero trips always, slot one never
    dev(1'h1, gac_pkg::OFS_PER_SEL, 0, 32'h26);
    dev(1'h1, gac_pkg::OFS_S0_TH_HI, 0, 32'h80);
    dev(1'h1, gac_pkg::OFS_S1_TH_LO, 0, 32'hff);
    dev(1'h1, gac_pkg::OFS_S1_TH_HI, 0, 32'h8f);
    dev(1'h1, gac_pkg::OFS_PER_CTRL, 0, 32'h07);
    waitIrq(1'b1);
    repeat (375) @(posedge clk); // Three periods with the flag left pending
    dev(1'h1, gac_pkg::OFS_PER_CTRL, 0, 32'h00);
    repeat (600) @(posedge clk); // Lets a conversion in flight finish
    dev(1'h0, gac_pkg::OFS_S0_RES_LO, 32'hff, {24'h0, lastRes[2][7:0]});
    dev(1'h0, gac_pkg::OFS_S0_RES_HI, 32'h0f, {28'h0, lastRes[2][11:8]});
    dev(1'h0, gac_pkg::OFS_S1_RES_HI, 32'h0f, {28'h0, lastRes[6][11:8]});
    dev(1'h0, gac_pkg::OFS_STATUS, 32'h06, 32'h02);
    rdx(gac_pkg::AV_STATUS, 32'h04, 32'h04);
    dev(1'h1, gac_pkg::OFS_STATUS, 0, 32'h06);
    // Sleep refuses a one-shot on the test channel; no done flag follows
    slp <= 1'h1;
    dev(1'h1, gac_pkg::OFS_OS_SEL, 0, 32'h17);
    repeat (300) @(posedge clk);
    dev(1'h0, gac_pkg::OFS_STATUS, 32'h09, 32'h08);
    // Equal trims give unit gain, so the code only loses the offset
    av(1'h1, gac_pkg::AV_TRIM_AB, 32'h0404);
    av(1'h1, gac_pkg::AV_CAL, 32'h0abc);
    repeat (30) @(posedge clk);
    rdx(gac_pkg::AV_CAL, 32'h1fff, 32'h0ab8);
    rdx(5'h1c, 32'hffffffff, 32'h0);
    conclude();
  end
endmodule
